// >>> verilog/sfb_pkg.sv
// Shared constants, types and command decode for the serial flash front end
package sfb_pkg;
    // Clock rate and timing (times in ns, counts in clk cycles, dummy count in link clock cycles)
    localparam int SFB_CLK_NS = 25;
    localparam int SFB_SCLK_HALF_NS = 100;
    localparam int SFB_SCLK_HALF_CYC = (SFB_SCLK_HALF_NS + SFB_CLK_NS - 1) / SFB_CLK_NS;
    localparam int SFB_CS_GAP_NS = 100;
    localparam int SFB_CS_GAP_CYC = (SFB_CS_GAP_NS + SFB_CLK_NS - 1) / SFB_CLK_NS;
    localparam int SFB_DUMMY_CYC = 8;
    localparam int SFB_ADDR_BITS = 32;

    // Array organisation
    localparam logic [24:0] SFB_ARRAY_TOP = 25'h1FF_FFFF;
    localparam int SFB_SECT_LSB = 12;
    localparam int SFB_B32_LSB = 15;
    localparam int SFB_B64_LSB = 16;
    localparam logic [8:0] SFB_B64_FIRST = 9'h000;
    localparam logic [8:0] SFB_B64_LAST = 9'h1FF;

    // Recognised opcodes
    localparam logic [7:0] SFB_OP_READ = 8'h03;
    localparam logic [7:0] SFB_OP_FAST_READ = 8'h0B;
    localparam logic [7:0] SFB_OP_QUAD_READ = 8'hEB;
    localparam logic [7:0] SFB_OP_PROG = 8'h02;
    localparam logic [7:0] SFB_OP_QUAD_PROG = 8'h38;
    localparam logic [7:0] SFB_OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] SFB_OP_B32_ERASE = 8'h52;
    localparam logic [7:0] SFB_OP_B64_ERASE = 8'hD8;
    localparam logic [7:0] SFB_OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] SFB_OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] SFB_OP_QUAD_ENTRY = 8'h35;
    localparam logic [7:0] SFB_OP_QUAD_EXIT = 8'hF5;

    // Frame phases and command classes
    typedef enum logic [4:0] {
        PH_CMD = 5'h01, PH_ADDR = 5'h02, PH_DUMMY = 5'h04, PH_DATA = 5'h08, PH_STBY = 5'h10
    } sfb_phase_e;
    typedef enum logic [2:0] {CL_BAD = 3'h1, CL_READ = 3'h2, CL_WRITE = 3'h4} sfb_class_e;

    // Command class from opcode
    function automatic sfb_class_e sfb_class(input logic [7:0] op);
        case (op)
            SFB_OP_READ, SFB_OP_FAST_READ, SFB_OP_QUAD_READ: sfb_class = CL_READ;
            SFB_OP_PROG, SFB_OP_QUAD_PROG, SFB_OP_SECT_ERASE, SFB_OP_B32_ERASE, SFB_OP_B64_ERASE,
            SFB_OP_CHIP_ERASE_A, SFB_OP_CHIP_ERASE_B, SFB_OP_QUAD_ENTRY, SFB_OP_QUAD_EXIT: sfb_class = CL_WRITE;
            default: sfb_class = CL_BAD;
        endcase
    endfunction

    // Commands that carry four address bytes
    function automatic logic sfb_has_addr(input logic [7:0] op);
        sfb_has_addr = (sfb_class(op) != CL_BAD) && (op != SFB_OP_CHIP_ERASE_A) && (op != SFB_OP_CHIP_ERASE_B)
            && (op != SFB_OP_QUAD_ENTRY) && (op != SFB_OP_QUAD_EXIT);
    endfunction

    // Reads with dummy cycles
    function automatic logic sfb_has_dummy(input logic [7:0] op);
        sfb_has_dummy = (op == SFB_OP_FAST_READ) || (op == SFB_OP_QUAD_READ);
    endfunction

    // Commands that touch the array
    function automatic logic sfb_is_array(input logic [7:0] op);
        sfb_is_array = sfb_has_addr(op) || (op == SFB_OP_CHIP_ERASE_A) || (op == SFB_OP_CHIP_ERASE_B);
    endfunction
endpackage

// >>> verilog/sfb_link_if.sv
// Serial flash link between host end and device end
`timescale 1ns/10ps
interface sfb_link_if;
    logic sclk;
    logic cs_n;
    logic [3:0] h_o;
    logic [3:0] h_oe;
    logic [3:0] d_o;
    logic [3:0] d_oe;
    logic [3:0] io;

    // Line level: driver wins, otherwise pulled high
    assign io = (h_o & h_oe) | (d_o & d_oe) | ~(h_oe | d_oe);

    modport host (output sclk, output cs_n, output h_o, output h_oe, input io);
    modport dev (input sclk, input cs_n, input io, output d_o, output d_oe);
endinterface

// >>> verilog/sfb_dev.sv
// Device end: serial frame decode on the link clock, command results on clk
// What this block does
// RQ1 - 8192 4K sectors, 32K/64K blocks, 25-bit addresses
// RQ2 - Sector locks in end blocks, block locks elsewhere
// RQ3 - Host polls status before issuing commands; neither end here issues a status read
// RQ4 - Unknown command: standby, output off till CS
// RQ5 - Valid command stays active until CS rises
// RQ6 - Sample on rising clock, launch on falling
// RQ7 - Works with clock idle low or high
// RQ8 - Reads stream data until host raises CS
// RQ9 - Write commands need CS on byte boundary
// RQ10 - Array access ignored while write busy
// RQ11 - All addressed commands take 32-bit address
// RQ12 - Entry opcode switches to 4-4-4, enable untouched
// RQ13 - Exit opcode returns to single-wire commands
// RQ14 - Pause stops link only, not internal work
// RQ15 - Pause starts on pause low, clock low
// RQ16 - Pause ends on pause high, clock low
// RQ17 - Paused: output off, clock and input ignored
// RQ18 - CS rising during pause resets link logic
// RQ19 - Pause pin doubles as fourth data line
// RQ20 - Quad mode disables hardware write protect
// RQ21 - Quad mode makes pause unavailable
`timescale 1ns/10ps
module sfb_dev (
    // Link
    sfb_link_if.dev link,
    // System
    input wire logic clk,
    input wire logic reset,
    // User side
    input wire logic busy,
    input wire logic [7:0] rd_byte,
    output logic cmd_valid,
    output logic [7:0] cmd_op,
    output logic [31:0] cmd_addr,
    output logic [12:0] sector_idx,
    output logic [9:0] blk32_idx,
    output logic [8:0] blk64_idx,
    output logic lock_is_sector,
    output logic [12:0] lock_unit,
    output logic cmd_reject,
    output logic cmd_ignored,
    output logic quad_command_mode,
    output logic hardware_protect_mode
);
    import sfb_pkg::*;

    typedef struct packed {
        sfb_phase_e phase;
        logic [5:0] cnt;
        logic [7:0] op;
        logic [31:0] addr;
        logic [2:0] bit3;
        logic paused;
        logic first;
        logic busy_s1;
        logic busy_s2;
    } sfb_frame_s;

    typedef struct packed {
        logic [7:0] op;
        logic [31:0] addr;
        sfb_class_e cls;
        logic aligned;
        logic tog;
    } sfb_snap_s;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } sfb_out_s;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic tog_s1;
        logic tog_s2;
        logic seen;
        logic wp_s1;
        logic wp_s2;
        logic quad;
        logic hwp;
        logic valid;
        logic [7:0] op;
        logic [31:0] addr;
        logic reject;
        logic ignored;
    } sfb_sys_s;

    sfb_frame_s fr_q, fr_d;
    sfb_snap_s sn_q, sn_d;
    sfb_out_s ob_q, ob_d;
    sfb_sys_s sy_q, sy_d;
    logic [5:0] nb;
    logic [5:0] cnt_n;
    logic accept;
    logic [24:0] arr;
    logic [8:0] b64;

    // Link-side bit handling on rising clock; quad flag only changes with CS high
    always_comb begin
        nb = sy_q.quad ? 6'd4 : 6'd1;
        cnt_n = fr_q.cnt + nb;
        accept = sy_q.quad | link.io[3]; // [RQ15] [RQ16] [RQ19] [RQ21]
        fr_d = fr_q;
        fr_d.first = 1'b0;
        fr_d.busy_s1 = busy;
        fr_d.busy_s2 = fr_q.busy_s1;
        fr_d.paused = ~accept; // [RQ17]
        if (accept && fr_q.phase != PH_STBY) begin
            fr_d.bit3 = fr_q.bit3 + nb[2:0];
            case (fr_q.phase)
                PH_CMD: begin
                    fr_d.op = sy_q.quad ? {fr_q.op[3:0], link.io} : {fr_q.op[6:0], link.io[0]}; // [RQ6] [RQ12]
                    fr_d.cnt = cnt_n;
                    if (cnt_n == 6'd8) begin
                        fr_d.cnt = 6'd0;
                        if (sfb_class(fr_d.op) == CL_BAD) begin
                            fr_d.phase = PH_STBY; // [RQ4]
                        end else if (sfb_has_addr(fr_d.op)) begin
                            fr_d.phase = PH_ADDR; // [RQ5]
                        end else begin
                            fr_d.phase = PH_DATA;
                        end
                    end
                end
                PH_ADDR: begin
                    fr_d.addr = sy_q.quad ? {fr_q.addr[27:0], link.io} : {fr_q.addr[30:0], link.io[0]};
                    fr_d.cnt = cnt_n;
                    if (cnt_n == 6'(SFB_ADDR_BITS)) begin // [RQ11]
                        fr_d.cnt = 6'd0;
                        fr_d.phase = sfb_has_dummy(fr_q.op) ? PH_DUMMY : PH_DATA;
                    end
                end
                PH_DUMMY: begin
                    fr_d.cnt = fr_q.cnt + 6'd1;
                    if (fr_q.cnt == 6'(SFB_DUMMY_CYC - 1)) begin
                        fr_d.cnt = 6'd0;
                        fr_d.phase = PH_DATA;
                    end
                end
                PH_DATA: begin
                    fr_d.cnt = {3'd0, cnt_n[2:0]}; // [RQ8]
                end
                default: begin
                    fr_d.phase = PH_STBY;
                end
            endcase
        end
        sn_d.op = fr_d.op;
        sn_d.addr = fr_d.addr;
        sn_d.cls = (fr_d.phase == PH_CMD) ? CL_BAD : sfb_class(fr_d.op);
        sn_d.aligned = (fr_d.bit3 == 3'd0); // [RQ9]
        sn_d.tog = sn_q.tog ^ fr_q.first;
    end

    // Frame state, cleared by CS high, also ending any pause
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            fr_q <= '{phase: PH_CMD, cnt: 6'd0, op: 8'h00, addr: 32'h0000_0000, bit3: 3'd0,
                      paused: 1'b0, first: 1'b1, busy_s1: 1'b0, busy_s2: 1'b0}; // [RQ18]
        end else begin
            fr_q <= fr_d;
        end
    end

    // Frame snapshot, held while CS is high
    always_ff @(posedge link.sclk or posedge reset) begin
        if (reset) begin
            sn_q <= '{op: 8'h00, addr: 32'h0000_0000, cls: CL_BAD, aligned: 1'b0, tog: 1'b0};
        end else if (!link.cs_n) begin
            sn_q <= sn_d;
        end
    end

    // Output launch on falling clock; off in standby, pause or busy array read
    always_comb begin
        ob_d.o = 4'h0;
        ob_d.oe = 4'h0;
        if (fr_q.phase == PH_DATA && sfb_class(fr_q.op) == CL_READ && !fr_q.paused && !fr_q.busy_s2) begin // [RQ10]
            if (sy_q.quad) begin
                ob_d.o = fr_q.cnt[2] ? rd_byte[3:0] : rd_byte[7:4];
                ob_d.oe = 4'hF;
            end else begin
                ob_d.o = {2'b00, rd_byte[3'd7 - fr_q.cnt[2:0]], 1'b0}; // [RQ6] [RQ7]
                ob_d.oe = 4'h2;
            end
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            ob_q <= '{o: 4'h0, oe: 4'h0}; // [RQ4] [RQ17]
        end else begin
            ob_q <= ob_d;
        end
    end

    assign link.d_o = ob_q.o;
    assign link.d_oe = ob_q.oe;

    // End-of-frame evaluation on clk after CS rises
    always_comb begin
        sy_d = sy_q;
        sy_d.cs_s1 = link.cs_n;
        sy_d.cs_s2 = sy_q.cs_s1;
        sy_d.cs_s3 = sy_q.cs_s2;
        sy_d.tog_s1 = sn_q.tog;
        sy_d.tog_s2 = sy_q.tog_s1;
        sy_d.wp_s1 = link.io[2];
        sy_d.wp_s2 = sy_q.wp_s1;
        sy_d.hwp = ~sy_q.quad & ~sy_q.wp_s2; // [RQ20]
        sy_d.valid = 1'b0;
        sy_d.reject = 1'b0;
        sy_d.ignored = 1'b0;
        if (sy_q.cs_s2 && !sy_q.cs_s3 && sy_q.tog_s2 != sy_q.seen) begin
            sy_d.seen = sy_q.tog_s2;
            if (sn_q.cls == CL_WRITE) begin
                if (!sn_q.aligned) begin
                    sy_d.reject = 1'b1; // [RQ9]
                end else if (busy && sfb_is_array(sn_q.op)) begin
                    sy_d.ignored = 1'b1; // [RQ10] [RQ14]
                end else begin
                    sy_d.valid = 1'b1;
                    sy_d.op = sn_q.op;
                    sy_d.addr = sn_q.addr;
                    if (sn_q.op == SFB_OP_QUAD_ENTRY) begin
                        sy_d.quad = 1'b1; // [RQ12]
                    end else if (sn_q.op == SFB_OP_QUAD_EXIT) begin
                        sy_d.quad = 1'b0; // [RQ13]
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sy_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, tog_s1: 1'b0, tog_s2: 1'b0, seen: 1'b0,
                      wp_s1: 1'b1, wp_s2: 1'b1, quad: 1'b0, hwp: 1'b0, valid: 1'b0, op: 8'h00,
                      addr: 32'h0000_0000, reject: 1'b0, ignored: 1'b0};
        end else begin
            sy_q <= sy_d;
        end
    end

    // Address into array geometry and lock unit
    assign arr = sy_q.addr[24:0] & SFB_ARRAY_TOP; // [RQ1]
    assign b64 = arr[24:SFB_B64_LSB];

    assign cmd_valid = sy_q.valid;
    assign cmd_op = sy_q.op;
    assign cmd_addr = sy_q.addr;
    assign sector_idx = arr[24:SFB_SECT_LSB]; // [RQ1]
    assign blk32_idx = arr[24:SFB_B32_LSB];
    assign blk64_idx = b64;
    assign lock_is_sector = (b64 == SFB_B64_FIRST) || (b64 == SFB_B64_LAST); // [RQ2]
    assign lock_unit = lock_is_sector ? arr[24:SFB_SECT_LSB] : {4'h0, b64}; // [RQ2]
    assign cmd_reject = sy_q.reject;
    assign cmd_ignored = sy_q.ignored;
    assign quad_command_mode = sy_q.quad;
    assign hardware_protect_mode = sy_q.hwp;
endmodule // sfb_dev

// >>> verilog/sfb_host.sv
// Host end: makes the link clock and frames commands from user requests
`timescale 1ns/10ps
module sfb_host #(
    parameter int HALF_CYC = sfb_pkg::SFB_SCLK_HALF_CYC,
    parameter int GAP_CYC = sfb_pkg::SFB_CS_GAP_CYC
) (
    // Link
    sfb_link_if.host link,
    // System
    input wire logic clk,
    input wire logic reset,
    // Request
    input wire logic start,
    input wire logic [7:0] op,
    input wire logic [31:0] addr,
    input wire logic [8:0] n_bytes,
    input wire logic [7:0] wr_byte,
    input wire logic mode3,
    input wire logic wp_level,
    input wire logic pause_req,
    // Answer
    output logic busy,
    output logic done,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic quad
);
    import sfb_pkg::*;

    typedef enum logic [2:0] {H_IDLE = 3'h1, H_RUN = 3'h2, H_GAP = 3'h4} sfb_hst_e;

    typedef struct packed {
        sfb_hst_e st;
        sfb_phase_e ph;
        logic [7:0] div;
        logic [5:0] units;
        logic [8:0] rem;
        logic [39:0] txs;
        logic [7:0] rxs;
        logic [7:0] op;
        logic mode3;
        logic fresh;
        logic sclk;
        logic cs_n;
        logic hold;
        logic [3:0] o;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        logic done;
        logic rd_valid;
        logic [7:0] rd_data;
        logic quad;
    } sfb_host_s;

    sfb_host_s q, d;
    logic [5:0] per_byte;
    logic rd_op;
    logic drive;

    always_comb begin
        per_byte = q.quad ? 6'd2 : 6'd8;
        rd_op = (sfb_class(q.op) == CL_READ);
        d = q;
        d.io_s1 = link.io;
        d.io_s2 = q.io_s1;
        d.done = 1'b0;
        d.rd_valid = 1'b0;
        d.div = q.div + 8'd1;
        case (q.st)
            H_IDLE: begin
                d.div = 8'd0;
                d.sclk = mode3; // [RQ7]
                if (start) begin
                    d.st = H_RUN;
                    d.op = op;
                    d.mode3 = mode3;
                    d.fresh = mode3;
                    d.cs_n = 1'b0;
                    d.ph = PH_CMD;
                    d.units = per_byte;
                    d.rem = n_bytes;
                    d.txs = {op, addr}; // [RQ11]
                    d.o = q.quad ? op[7:4] : {3'b000, op[7]};
                end
            end
            H_RUN: begin
                if (q.div == 8'(HALF_CYC - 1)) begin
                    d.div = 8'd0;
                    if (!q.sclk) begin
                        // Pause only with clock low and not in quad mode
                        d.hold = pause_req & ~q.quad; // [RQ15] [RQ16] [RQ21]
                        if (!d.hold && !q.hold) begin
                            d.sclk = 1'b1; // [RQ6]
                            d.rxs = q.quad ? {q.rxs[3:0], q.io_s2} : {q.rxs[6:0], q.io_s2[1]};
                            d.txs = q.quad ? {q.txs[35:0], 4'h0} : {q.txs[38:0], 1'b0};
                            d.units = q.units - 6'd1;
                            if (q.ph == PH_DATA && rd_op && q.units == 6'd1) begin
                                d.rd_valid = 1'b1; // [RQ8]
                                d.rd_data = d.rxs;
                            end
                            if (q.units == 6'd1) begin
                                d.units = per_byte;
                                case (q.ph)
                                    PH_CMD, PH_ADDR, PH_DUMMY: begin
                                        if (q.ph == PH_CMD && sfb_has_addr(q.op)) begin
                                            d.ph = PH_ADDR;
                                            d.units = q.quad ? 6'd8 : 6'd32;
                                        end else if (q.ph != PH_DUMMY && sfb_has_dummy(q.op)) begin
                                            d.ph = PH_DUMMY;
                                            d.units = 6'(SFB_DUMMY_CYC);
                                        end else if (q.rem != 9'd0 && sfb_is_array(q.op)) begin
                                            d.ph = PH_DATA;
                                            d.txs[39:32] = wr_byte;
                                        end else begin
                                            d.ph = PH_STBY; // [RQ9]
                                        end
                                    end
                                    PH_DATA: begin
                                        d.rem = q.rem - 9'd1;
                                        d.txs[39:32] = wr_byte;
                                        if (q.rem == 9'd1) begin
                                            d.ph = PH_STBY; // [RQ9]
                                        end
                                    end
                                    default: begin
                                        d.ph = PH_STBY;
                                    end
                                endcase
                            end
                        end
                    end else begin
                        // Falling edge: launch next bits or end the frame
                        d.sclk = 1'b0;
                        d.fresh = 1'b0;
                        d.o = q.quad ? q.txs[39:36] : {3'b000, q.txs[39]}; // [RQ6]
                        if (q.ph == PH_STBY && !q.fresh) begin
                            d.st = H_GAP;
                            d.cs_n = 1'b1;
                            d.sclk = q.mode3;
                            d.done = 1'b1;
                            if (q.op == SFB_OP_QUAD_ENTRY) begin
                                d.quad = 1'b1;
                            end else if (q.op == SFB_OP_QUAD_EXIT) begin
                                d.quad = 1'b0;
                            end
                        end
                    end
                end
            end
            H_GAP: begin
                if (q.div == 8'(GAP_CYC - 1)) begin
                    d.st = H_IDLE;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{st: H_IDLE, ph: PH_CMD, div: 8'd0, units: 6'd0, rem: 9'd0, txs: 40'h00_0000_0000,
                   rxs: 8'h00, op: 8'h00, mode3: 1'b0, fresh: 1'b0, sclk: 1'b0, cs_n: 1'b1, hold: 1'b0,
                   o: 4'h0, io_s1: 4'hF, io_s2: 4'hF, done: 1'b0, rd_valid: 1'b0, rd_data: 8'h00, quad: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Host drives data lines in a quad frame except in the dummy, data and standby phases of a read; in single mode it always drives lines 0, 2 and 3
    assign drive = (q.st == H_RUN) && !(rd_op && q.ph != PH_CMD && q.ph != PH_ADDR);
    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.h_o = q.quad ? q.o : {~q.hold, wp_level, 1'b0, q.o[0]}; // [RQ19]
    assign link.h_oe = q.quad ? {4{drive}} : 4'b1101;
    assign busy = (q.st != H_IDLE);
    assign done = q.done;
    assign rd_valid = q.rd_valid;
    assign rd_data = q.rd_data;
    assign quad = q.quad;
endmodule // sfb_host

// >>> testbench/sfb_link_asserts.sv
// Link protocol checker for the serial flash front end
`timescale 1ns/10ps
module sfb_link_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] h_o,
    input wire logic [3:0] h_oe,
    input wire logic [3:0] d_o,
    input wire logic [3:0] d_oe,
    input wire logic [3:0] io
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Device output only inside a frame
    a_idle_quiet: assert property (cs_n |-> d_oe == 4'h0)
        else $error("device drives while deselected");
    a_cmd_quiet: assert property ($fell(cs_n) |-> (d_oe == 4'h0) [*8])
        else $error("device drives during command");
    a_oe_shape: assert property (d_oe inside {4'h0, 4'h2, 4'hF})
        else $error("device enable pattern wrong");
    a_no_fight: assert property ((h_oe & d_oe) == 4'h0)
        else $error("both ends drive one line");

    // Launch edges of both ends
    a_dev_launch: assert property ((d_oe != 4'h0 && $past(d_oe) != 4'h0 && $changed(d_o)) |-> $fell(sclk))
        else $error("device data changed off falling clock");
    a_host_launch: assert property (($changed(h_o) && !cs_n && $past(!cs_n)) |-> !sclk)
        else $error("host data changed with clock high");

    // Clock phases and frame spacing
    a_half_period: assert property (($changed(sclk) && !cs_n) |=> (cs_n || $stable(sclk)) [*3])
        else $error("link clock phase too short");
    a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("deselect time too short");
endmodule // sfb_link_asserts

// >>> testbench/tb_top.sv
// Self-checking bench joining host end and device end
`timescale 1ns/10ps
module tb_top;
    import sfb_pkg::*;
    logic clk, reset, abort, start, mode3, wp_level, pause_req, busy_in, h_busy, rd_valid, quad;
    logic cmd_valid, lock_is_sector, cmd_reject, cmd_ignored, quad_command_mode, hardware_protect_mode;
    logic [7:0] op, wr_byte, rd_byte, rd_data, cmd_op;
    logic [31:0] addr, cmd_addr;
    logic [8:0] n_bytes, blk64_idx;
    logic [12:0] sector_idx, lock_unit;
    logic [9:0] blk32_idx;
    int failures, tests_run, n_val, n_rej, n_ign, v, w, seed;
    logic [7:0] rq[$];
    logic [7:0] wops [6] = '{SFB_OP_SECT_ERASE, SFB_OP_B32_ERASE, SFB_OP_B64_ERASE, SFB_OP_PROG, SFB_OP_PROG, 8'h20};
    logic [31:0] adrs [4] = '{32'h0000_0000, 32'h01FF_FFFF, 32'h01FF_0000, 32'h0001_0000};

    sfb_link_if u_sfb_link_if ();
    sfb_host u_sfb_host (.link(u_sfb_link_if.host), .clk(clk), .reset(reset | abort), .start(start), .op(op),
        .addr(addr), .n_bytes(n_bytes), .wr_byte(wr_byte), .mode3(mode3), .wp_level(wp_level),
        .pause_req(pause_req), .busy(h_busy), .done(), .rd_valid(rd_valid), .rd_data(rd_data), .quad(quad));
    sfb_dev u_sfb_dev (.link(u_sfb_link_if.dev), .clk(clk), .reset(reset), .busy(busy_in), .rd_byte(rd_byte),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .sector_idx(sector_idx),
        .blk32_idx(blk32_idx), .blk64_idx(blk64_idx), .lock_is_sector(lock_is_sector), .lock_unit(lock_unit),
        .cmd_reject(cmd_reject), .cmd_ignored(cmd_ignored), .quad_command_mode(quad_command_mode),
        .hardware_protect_mode(hardware_protect_mode));
    sfb_link_asserts u_chk (.clk(clk), .reset(reset), .sclk(u_sfb_link_if.sclk), .cs_n(u_sfb_link_if.cs_n),
        .h_o(u_sfb_link_if.h_o), .h_oe(u_sfb_link_if.h_oe), .d_o(u_sfb_link_if.d_o),
        .d_oe(u_sfb_link_if.d_oe), .io(u_sfb_link_if.io));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Count device pulses and collect read bytes
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) n_val++;
        if (cmd_reject === 1'b1) n_rej++;
        if (cmd_ignored === 1'b1) n_ign++;
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task step;
        @(posedge clk);
        #2;
    endtask

    // Sector granularity only in the two end blocks
    function automatic logic lock_sec(input logic [31:0] a);
        return a[24:16] == 9'h000 || a[24:16] == 9'h1FF;
    endfunction

    task automatic frame(input logic [7:0] o, input logic [31:0] a, input logic [8:0] n);
        int k;
        op = o;
        addr = a;
        n_bytes = n;
        wr_byte = $random(seed);
        start = 1'b1;
        step;
        start = 1'b0;
        step;
        k = 0;
        while (h_busy !== 1'b0 && k < 5000) begin
            step;
            k++;
        end
        repeat (6) step;
    endtask

    task automatic chk_wr(input logic [7:0] o, input logic [31:0] a);
        int c;
        c = n_val;
        frame(o, a, 9'd1);
        check(n_val - c, 1);
        check(cmd_op, o);
        check(cmd_addr, a);
        check(sector_idx, a[24:12]);
        check(blk32_idx, a[24:15]);
        check(blk64_idx, a[24:16]);
        check(lock_is_sector, lock_sec(a));
        check(lock_unit, lock_sec(a) ? a[24:12] : {4'h0, a[24:16]});
    endtask

    task automatic chk_rd(input logic [7:0] o, input logic [8:0] n, input logic off);
        rq.delete();
        rd_byte = $random(seed);
        frame(o, $random(seed), n);
        if (!off) check(rq.size(), n);
        foreach (rq[i]) check(rq[i], off ? 8'hFF : rd_byte);
    endtask

    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        final_report;
    end

    // Main sequence
    initial begin
        {reset, abort, start, mode3, pause_req, busy_in} = 6'h3F & 6'h20;
        {op, wr_byte, rd_byte, addr, n_bytes} = '0;
        wp_level = 1'b1;
        seed = 32'h5df6e191;
        {failures, tests_run, n_val, n_rej, n_ign} = '0;
        repeat (16) @(posedge clk);
        #2 reset = 1'b0;
        for (int m = 0; m < 2; m++) begin
            mode3 = m[0];
            step;
            for (int i = 0; i < 6; i++) chk_wr(wops[i], i < 4 ? adrs[i] : $random(seed));
            chk_rd(SFB_OP_READ, 9'd3, 1'b0);
            chk_rd(SFB_OP_FAST_READ, 9'd2, 1'b0);
            v = n_val + n_rej;
            chk_rd(8'hA5, 9'd2, 1'b1);
            check(n_val + n_rej, v);
            $display("mode %0d frames done", m);
        end
        foreach (wops[i]) if (i < 2) begin
            v = n_val;
            frame(i ? SFB_OP_CHIP_ERASE_B : SFB_OP_CHIP_ERASE_A, 32'h0, 9'd0);
            check(n_val - v, 1);
            check(cmd_op, i ? SFB_OP_CHIP_ERASE_B : SFB_OP_CHIP_ERASE_A);
        end
        // Array commands while the internal write runs
        busy_in = 1'b1;
        {v, w} = {n_ign, n_val};
        frame(SFB_OP_SECT_ERASE, 32'h0000_1000, 9'd0);
        check(n_ign - v, 1);
        check(n_val - w, 0);
        chk_rd(SFB_OP_READ, 9'd2, 1'b1);
        busy_in = 1'b0;
        // Frame cut short inside the address
        {v, w} = {n_rej, n_val};
        {op, addr, start} = {SFB_OP_SECT_ERASE, 32'h0002_3000, 1'b1};
        step;
        start = 1'b0;
        repeat (98) step;
        abort = 1'b1;
        repeat (2) step;
        abort = 1'b0;
        repeat (12) step;
        check(n_rej - v, 1);
        check(n_val - w, 0);
        // Pause during the address phase of a read
        fork
            chk_rd(SFB_OP_READ, 9'd2, 1'b0);
            begin
                repeat (150) step;
                pause_req = 1'b1;
                repeat (40) step;
                pause_req = 1'b0;
            end
        join
        $display("busy, abort and pause done");
        // Quad command mode entry and exit
        wp_level = 1'b0;
        chk_wr(SFB_OP_B32_ERASE, 32'h0100_8000);
        check(hardware_protect_mode, 1'b1);
        frame(SFB_OP_QUAD_ENTRY, 32'h0, 9'd0);
        check({quad, quad_command_mode, hardware_protect_mode}, 3'b110);
        pause_req = 1'b1;
        chk_rd(SFB_OP_QUAD_READ, 9'd2, 1'b0);
        pause_req = 1'b0;
        chk_wr(SFB_OP_B64_ERASE, $random(seed));
        frame(SFB_OP_QUAD_EXIT, 32'h0, 9'd0);
        check({quad, quad_command_mode}, 2'b00);
        chk_wr(SFB_OP_SECT_ERASE, 32'h01FF_8000);
        wp_level = 1'b1;
        $display("quad mode done");
        final_report;
    end
endmodule // tb_top
